// [inc/bpan_regs.svh]
`ifndef BPAN_REGS_SVH
`define BPAN_REGS_SVH
// Notes on behaviour
// - Each local technology ability bit is copied into its codeword ability bit
// - Ability bit 1 advertises support; 0 advertises no support
// - Local Reed-Solomon request sets its codeword request bit
// - Local Reed-Solomon ability sets its codeword ability bit
// - One 2-bit link control output per technology, on the block clock
// - Codes: 11 connected, 00 disconnected, 01 scanning, 10 never produced
// - Base-R correction enable when negotiation resolves its use
// - Reed-Solomon correction enable when negotiation resolves its use
// - Pause generate enable lets transmit path send global pause frames
// - Pause obey enable lets receive path act on global pause frames
// - Done only after negotiation finished and PCS receive link is up
// - Fault output raised when parallel detection fails
// - One-cycle pulse on each entry to transmit-disable, when enabled and not bypassed
// - One-cycle pulse on each entry to good-check, when enabled and not bypassed
// - Good-check pulse starts training if enabled, else mission mode
// - Bypass turns negotiation off but still connects the PCS
// - Restart returns negotiation to transmit-disable from any state, when enabled and not bypassed
// - Local pause advertisement drives codeword bit C0

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define BPAN_NTECH        15
`define BPAN_CW_W         48
`define BPAN_CTRL_W       10
// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define BPAN_OFF_CTRL     8'h00
`define BPAN_OFF_ABIL     8'h04
`define BPAN_OFF_STATUS   8'h08
`define BPAN_OFF_LINKCTL  8'h0c
`define BPAN_CTRL_RESTART 2
`define BPAN_CTRL_RST     10'h000
`define BPAN_ABIL_RST     15'h0000
// ----------------------------------------------------------------
// Codeword bit positions
// ----------------------------------------------------------------
`define BPAN_CW_C0        10
`define BPAN_CW_C1        11
`define BPAN_CW_ACK       14
`define BPAN_CW_ABIL      21
`define BPAN_CW_RS_REQ    42
`define BPAN_CW_RS_ABIL   43
`define BPAN_CW_BR_ABIL   46
`define BPAN_CW_BR_REQ    47
// Technologies using each correction, by priority index
`define BPAN_BASER_MASK   15'h0184
`define BPAN_RS_MASK      15'h7678
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BPAN_CLK_NS       4
`define BPAN_HOLD_NS      256
`define BPAN_LINK_WAIT_NS 4000
`define BPAN_HOLD_CYCLES  ((`BPAN_HOLD_NS + `BPAN_CLK_NS - 1) / `BPAN_CLK_NS)
`define BPAN_WAIT_CYCLES  (`BPAN_LINK_WAIT_NS / `BPAN_CLK_NS)
`endif

// [inc/bpan_pkg.sv]
`include "bpan_regs.svh"
package bpan_pkg;
  typedef enum logic [5:0] {
    ST_OFF  = 6'h01,
    ST_TXD  = 6'h02,
    ST_ABIL = 6'h04,
    ST_ACK  = 6'h08,
    ST_GC   = 6'h10,
    ST_GOOD = 6'h20
  } bpan_state_t;

  typedef enum logic [1:0] {
    LC_OFF  = 2'h0,
    LC_SCAN = 2'h1,
    LC_ON   = 2'h3
  } bpan_lc_t;

  typedef struct packed {
    logic baser_request;
    logic baser_ability;
    logic rs_correction_ability_in;
    logic rs_correction_request_in;
    logic asm_dir_adv;
    logic local_pause_adv;
    logic training_on;
    logic restart;
    logic bypass;
    logic enable;
  } bpan_ctrl_t;

  typedef struct packed {
    logic pause_obey_on;
    logic pause_generate_on;
    logic rs_correction_on;
    logic baser_correction_on;
    logic parallel_detect_error;
    logic negotiation_done;
  } bpan_status_t;

  // Highest set bit wins
  function automatic logic [`BPAN_NTECH-1:0] top_bit(input logic [`BPAN_NTECH-1:0] v);
    top_bit = '0;
    for (int i = 0; i < `BPAN_NTECH; i++) begin
      if (v[i]) begin
        top_bit    = '0;
        top_bit[i] = 1'b1;
      end
    end
  endfunction : top_bit

  function automatic logic [`BPAN_NTECH-1:0] code_mask(input logic [`BPAN_NTECH-1:0][1:0] v,
                                                      input logic [1:0] code);
    for (int i = 0; i < `BPAN_NTECH; i++) begin
      code_mask[i] = (v[i] == code);
    end
  endfunction : code_mask
endpackage : bpan_pkg

// [rtl/bpan_sync2.sv]
`timescale 1ns/100ps
`include "bpan_regs.svh"
module bpan_sync2
  import bpan_pkg::*;
#(
  parameter int P_W = 1
) (
  // Clock and reset
  input  wire logic           i_clock,
  input  wire logic           i_rst,
  input  wire logic           i_clk_en,
  // Data
  input  wire logic [P_W-1:0] i_d,
  output logic      [P_W-1:0] o_q
);
  logic [P_W-1:0] meta;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta <= '0;
      o_q  <= '0;
    end else if (i_clk_en) begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule : bpan_sync2

// [rtl/bpan_resolve.sv]
`timescale 1ns/100ps
`include "bpan_regs.svh"
module bpan_resolve
  import bpan_pkg::*;
(
  // Codewords
  input  wire logic [`BPAN_CW_W-1:0]  i_local_word,
  input  wire logic [`BPAN_CW_W-1:0]  i_partner_word,
  // Resolution
  output logic      [`BPAN_NTECH-1:0] o_tech,
  output logic                        o_any,
  output logic                        o_baser_on,
  output logic                        o_rs_on,
  output logic                        o_pause_generate,
  output logic                        o_pause_obey
);
  logic [`BPAN_NTECH-1:0] common;
  logic                   lp;
  logic                   la;
  logic                   pp;
  logic                   pa;

  assign common = i_local_word[`BPAN_CW_ABIL +: `BPAN_NTECH] & i_partner_word[`BPAN_CW_ABIL +: `BPAN_NTECH];
  assign o_tech = top_bit(common);
  assign o_any  = |common;

  assign o_baser_on = o_any && |(o_tech & `BPAN_BASER_MASK)
                      && i_local_word[`BPAN_CW_BR_ABIL] && i_partner_word[`BPAN_CW_BR_ABIL]
                      && (i_local_word[`BPAN_CW_BR_REQ] || i_partner_word[`BPAN_CW_BR_REQ]);
  assign o_rs_on    = o_any && |(o_tech & `BPAN_RS_MASK)
                      && i_local_word[`BPAN_CW_RS_ABIL] && i_partner_word[`BPAN_CW_RS_ABIL]
                      && (i_local_word[`BPAN_CW_RS_REQ] || i_partner_word[`BPAN_CW_RS_REQ]);

  assign lp = i_local_word[`BPAN_CW_C0];
  assign la = i_local_word[`BPAN_CW_C1];
  assign pp = i_partner_word[`BPAN_CW_C0];
  assign pa = i_partner_word[`BPAN_CW_C1];
  // Symmetric pause enables both; asymmetric enables one direction only
  assign o_pause_generate = (lp && pp) || (!lp && la && pp && pa);
  assign o_pause_obey     = (lp && pp) || (lp && la && !pp && pa);
endmodule : bpan_resolve

// [rtl/bpan_core.sv]
`timescale 1ns/100ps
`include "bpan_regs.svh"
module bpan_core
  import bpan_pkg::*;
#(
  parameter int P_NTECH            = `BPAN_NTECH,
  parameter int P_HOLD_CYCLES      = `BPAN_HOLD_CYCLES,
  parameter int P_LINK_WAIT_CYCLES = `BPAN_WAIT_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                         i_clock,
  input  wire logic                         i_rst,
  input  wire logic                         i_clk_en,
  // Register port
  input  wire logic [7:0]                   i_reg_addr,
  input  wire logic [31:0]                  i_reg_wdata,
  input  wire logic                         i_reg_write,
  input  wire logic                         i_reg_read,
  output logic      [31:0]                  o_reg_rdata,
  // Codeword exchange
  input  wire logic [`BPAN_CW_W-1:0]        i_rx_word,
  input  wire logic                         i_rx_word_valid,
  output logic      [`BPAN_CW_W-1:0]        o_tx_word,
  // PCS side, asynchronous
  input  wire logic                         i_pcs_rx_link_up,
  input  wire logic [P_NTECH-1:0]           i_scan_link_up,
  // Results
  output logic      [P_NTECH-1:0][1:0]      o_link_ctl,
  output bpan_status_t                      o_status,
  output logic                              o_negotiation_start_pulse,
  output logic                              o_good_check_entry_pulse,
  output logic                              o_training_start_pulse,
  output logic                              o_mission_start_pulse
);
  // ----------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------
  bpan_ctrl_t             ctrl;
  logic [P_NTECH-1:0]     adv;
  bpan_state_t            state;
  bpan_state_t            next_state;
  logic [15:0]            timer;
  logic [P_NTECH-1:0]     tech_sel;
  logic [`BPAN_CW_W-1:0]  lp_word;
  logic                   lp_valid;
  logic                   link_up_s;
  logic [P_NTECH-1:0]     scan_s;
  logic                   restart;
  logic                   run;
  logic                   enter_txd;
  logic                   enter_gc;
  logic [P_NTECH-1:0]     scan_hits;
  logic                   pd_single;
  logic                   pd_multi;
  logic [P_NTECH-1:0]     res_tech;
  logic                   res_any;
  logic                   res_baser;
  logic                   res_rs;
  logic                   res_gen;
  logic                   res_obey;
  logic [`BPAN_CW_W-1:0]  next_tx_word;
  wire logic [P_NTECH-1:0][1:0] next_link_ctl;

  localparam logic [15:0] HOLD_LOAD = 16'(P_HOLD_CYCLES - 1);
  localparam logic [15:0] WAIT_LOAD = 16'(P_LINK_WAIT_CYCLES - 1);

  assign restart = i_reg_write && (i_reg_addr == `BPAN_OFF_CTRL) && i_reg_wdata[`BPAN_CTRL_RESTART];
  assign run     = ctrl.enable && !ctrl.bypass;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl <= bpan_ctrl_t'(`BPAN_CTRL_RST);
    end else if (i_clk_en && i_reg_write && i_reg_addr == `BPAN_OFF_CTRL) begin
      ctrl         <= bpan_ctrl_t'(i_reg_wdata[`BPAN_CTRL_W-1:0]);
      ctrl.restart <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      adv <= `BPAN_ABIL_RST;
    end else if (i_clk_en && i_reg_write && i_reg_addr == `BPAN_OFF_ABIL) begin
      adv <= i_reg_wdata[P_NTECH-1:0];
    end
  end

  // Read data stands one cycle and is zero otherwise
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_reg_rdata <= '0;
    end else if (i_clk_en) begin
      o_reg_rdata <= '0;
      if (i_reg_read) begin
        case (i_reg_addr)
          `BPAN_OFF_CTRL:    o_reg_rdata <= 32'(ctrl);
          `BPAN_OFF_ABIL:    o_reg_rdata <= 32'(adv);
          `BPAN_OFF_STATUS:  o_reg_rdata <= {18'h0, state, 2'h0, o_status};
          `BPAN_OFF_LINKCTL: o_reg_rdata <= 32'(o_link_ctl);
          default:           o_reg_rdata <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Codewords
  // ----------------------------------------------------------------
  always_comb begin
    next_tx_word                                = '0;
    next_tx_word[`BPAN_CW_ABIL +: P_NTECH]      = adv;
    next_tx_word[`BPAN_CW_C0]                   = ctrl.local_pause_adv;
    next_tx_word[`BPAN_CW_C1]                   = ctrl.asm_dir_adv;
    next_tx_word[`BPAN_CW_RS_REQ]               = ctrl.rs_correction_request_in;
    next_tx_word[`BPAN_CW_RS_ABIL]              = ctrl.rs_correction_ability_in;
    next_tx_word[`BPAN_CW_BR_ABIL]              = ctrl.baser_ability;
    next_tx_word[`BPAN_CW_BR_REQ]               = ctrl.baser_request;
    next_tx_word[`BPAN_CW_ACK]                  = (state == ST_ACK);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_tx_word <= '0;
    end else if (i_clk_en) begin
      o_tx_word <= next_tx_word;
    end
  end

  // Partner word is forgotten on every new attempt
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      lp_word  <= '0;
      lp_valid <= 1'b0;
    end else if (i_clk_en) begin
      if (next_state == ST_TXD || next_state == ST_OFF) begin
        lp_valid <= 1'b0;
      end else if (i_rx_word_valid) begin
        lp_word  <= i_rx_word;
        lp_valid <= 1'b1;
      end
    end
  end

  bpan_sync2 #(.P_W(1)) u_link_sync (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_clk_en (i_clk_en),
    .i_d      (i_pcs_rx_link_up),
    .o_q      (link_up_s)
  );

  bpan_sync2 #(.P_W(P_NTECH)) u_scan_sync (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_clk_en (i_clk_en),
    .i_d      (i_scan_link_up),
    .o_q      (scan_s)
  );

  bpan_resolve u_resolve (
    .i_local_word     (o_tx_word),
    .i_partner_word   (lp_word),
    .o_tech           (res_tech),
    .o_any            (res_any),
    .o_baser_on       (res_baser),
    .o_rs_on          (res_rs),
    .o_pause_generate (res_gen),
    .o_pause_obey     (res_obey)
  );

  assign scan_hits = scan_s & adv;
  assign pd_single = $onehot(scan_hits);
  assign pd_multi  = (scan_hits != '0) && !pd_single;

  // ----------------------------------------------------------------
  // Negotiation sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF:  if (run) next_state = ST_TXD;
      ST_TXD:  if (timer == '0) next_state = ST_ABIL;
      ST_ABIL: begin
        if (lp_valid) next_state = ST_ACK;
        else if (pd_single) next_state = ST_GC;
        else if (pd_multi) next_state = ST_TXD;
      end
      ST_ACK:  if (lp_valid && lp_word[`BPAN_CW_ACK]) next_state = res_any ? ST_GC : ST_TXD;
      ST_GC: begin
        if (link_up_s) next_state = ST_GOOD;
        else if (timer == '0) next_state = ST_TXD;
      end
      ST_GOOD: if (!link_up_s) next_state = ST_TXD;
      default: next_state = ST_OFF;
    endcase
    if (!run) next_state = ST_OFF;
    else if (restart) next_state = ST_TXD;
  end

  assign enter_txd = (next_state == ST_TXD) && (state != ST_TXD || restart);
  assign enter_gc  = (next_state == ST_GC) && (state != ST_GC);

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= ST_OFF;
    end else if (i_clk_en) begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      timer <= '0;
    end else if (i_clk_en) begin
      if (enter_txd) timer <= HOLD_LOAD;
      else if (enter_gc) timer <= WAIT_LOAD;
      else if (timer != '0) timer <= timer - 16'h0001;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tech_sel <= '0;
    end else if (i_clk_en) begin
      if (state == ST_OFF) tech_sel <= top_bit(adv);
      else if (enter_gc) tech_sel <= (state == ST_ABIL) ? scan_hits : res_tech;
      else if (next_state == ST_TXD) tech_sel <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Link control per technology
  // ----------------------------------------------------------------
  for (genvar g = 0; g < P_NTECH; g++) begin : g_lc
    // Code 10 is never built: only OFF, SCAN or ON reach the output
    assign next_link_ctl[g] =
      ((state == ST_OFF && ctrl.bypass) || state == ST_GC || state == ST_GOOD) && tech_sel[g] ? LC_ON :
      ((state == ST_ABIL || state == ST_ACK) && adv[g]) ? LC_SCAN : LC_OFF;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_link_ctl <= '0;
    end else if (i_clk_en) begin
      o_link_ctl <= next_link_ctl;
    end
  end

  // ----------------------------------------------------------------
  // Status and pulses
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_status <= '0;
    end else if (i_clk_en) begin
      o_status.negotiation_done <= (next_state == ST_GOOD);
      // Fault holds until a link comes up; a new fault wins over that clear
      if (state == ST_ABIL && pd_multi) o_status.parallel_detect_error <= 1'b1;
      else if (next_state == ST_GOOD) o_status.parallel_detect_error <= 1'b0;
      if (enter_gc) begin
        o_status.baser_correction_on <= (state == ST_ACK) && res_baser;
        o_status.rs_correction_on    <= (state == ST_ACK) && res_rs;
        o_status.pause_generate_on   <= (state == ST_ACK) && res_gen;
        o_status.pause_obey_on       <= (state == ST_ACK) && res_obey;
      end else if (next_state != ST_GC && next_state != ST_GOOD) begin
        o_status.baser_correction_on <= 1'b0;
        o_status.rs_correction_on    <= 1'b0;
        o_status.pause_generate_on   <= 1'b0;
        o_status.pause_obey_on       <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_negotiation_start_pulse <= 1'b0;
      o_good_check_entry_pulse  <= 1'b0;
      o_training_start_pulse    <= 1'b0;
      o_mission_start_pulse     <= 1'b0;
    end else if (i_clk_en) begin
      o_negotiation_start_pulse <= run && enter_txd;
      o_good_check_entry_pulse  <= run && enter_gc;
      o_training_start_pulse    <= run && enter_gc && ctrl.training_on;
      o_mission_start_pulse     <= run && enter_gc && !ctrl.training_on;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  a_start_pulse_once: assert property (o_negotiation_start_pulse && i_clk_en |=> !o_negotiation_start_pulse)
    else $error("start pulse longer than one cycle");
  a_start_on_entry: assert property (i_clk_en && run && enter_txd |=> o_negotiation_start_pulse && state == ST_TXD)
    else $error("no start pulse on entry to transmit disable");
  a_good_check_pulse: assert property (i_clk_en && run && enter_gc |=> o_good_check_entry_pulse ##0 state == ST_GC)
    else $error("no pulse on entry to good check");
  a_pulse_split: assert property (o_good_check_entry_pulse |-> o_training_start_pulse != o_mission_start_pulse)
    else $error("training and mission pulses disagree");
  a_done_link_up: assert property (o_status.negotiation_done |-> $past(link_up_s) && state == ST_GOOD)
    else $error("done without link up");
  a_no_code_ten: assert property (code_mask(o_link_ctl, 2'h2) == '0)
    else $error("reserved link control code");
  a_single_on: assert property (!ctrl.bypass |-> $onehot0(code_mask(o_link_ctl, LC_ON)))
    else $error("more than one technology connected");
  a_adv_in_word: assert property (i_clk_en |=> o_tx_word[`BPAN_CW_ABIL +: P_NTECH] == $past(adv))
    else $error("ability bits not carried");
  a_pause_in_word: assert property (i_clk_en |=> o_tx_word[`BPAN_CW_C0] == $past(ctrl.local_pause_adv))
    else $error("pause bit not carried");
  a_rs_in_word: assert property (i_clk_en |=> o_tx_word[`BPAN_CW_RS_REQ +: 2] == $past({ctrl.rs_correction_ability_in, ctrl.rs_correction_request_in}))
    else $error("correction bits not carried");
  a_restart_entry: assert property (i_clk_en && restart && run |=> state == ST_TXD ##0 timer == HOLD_LOAD)
    else $error("restart did not reinitialise");
  a_pd_fault: assert property (i_clk_en && state == ST_ABIL && pd_multi && !lp_valid |=> o_status.parallel_detect_error && state == ST_TXD)
    else $error("parallel detection fault missed");
  a_bypass_connect: assert property ((i_clk_en && ctrl.enable && ctrl.bypass && adv != '0 && !i_reg_write)[*4] |-> code_mask(o_link_ctl, LC_ON) == top_bit(adv))
    else $error("bypass did not connect PCS");
  a_fec_exclusive: assert property (o_status.baser_correction_on |-> !o_status.rs_correction_on && |(tech_sel & `BPAN_BASER_MASK))
    else $error("correction enable without matching technology");
  a_pause_table: assert property (o_status.pause_generate_on && o_status.pause_obey_on |-> $past(o_tx_word[`BPAN_CW_C0]) || o_tx_word[`BPAN_CW_C0])
    else $error("symmetric pause without local advertisement");

  c_done:    cover property (enter_gc ##[1:20] o_status.negotiation_done);
  c_fault:   cover property (o_status.parallel_detect_error);
  c_bypass:  cover property (ctrl.bypass && code_mask(o_link_ctl, LC_ON) != '0);
  c_restart: cover property (restart && state == ST_GOOD);
endmodule : bpan_core

// [tb/bpan_partner.sv]
`timescale 1ns/100ps
module bpan_partner (
  // Clock and page
  input  wire logic        i_clock,
  input  wire logic        i_send,
  input  wire logic [47:0] i_page,
  // Toward the block
  output logic      [47:0] o_word,
  output logic             o_valid
);
  logic [3:0]  left = 4'h0;
  logic [47:0] last = 48'h0;
  // ----
  // Page sender
  // ----
  // Idle word flips each cycle so a stale page is never mistaken for a live one
  always @(posedge i_clock) begin
    if (i_send) left <= 4'h8;
    else if (left != 4'h0) left <= left - 4'h1;
    last <= (i_send || left != 4'h0) ? (i_page | 48'h4000) : ~last;
  end
  assign o_word  = last;
  assign o_valid = (left != 4'h0);
endmodule : bpan_partner

// [tb/backplane_autoneg_ability_resolution_bench.sv]
`timescale 1ns/100ps
`include "bpan_regs.svh"
module backplane_autoneg_ability_resolution_bench;
  import bpan_pkg::*;
  logic             clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, send = 1'b0, lup = 1'b0, rxv;
  logic [7:0]       addr = 8'h00;
  logic [31:0]      wd = 32'h0, rdat;
  logic [47:0]      page = 48'h0, rxw, txw;
  logic [14:0]      scan = 15'h0;
  logic [14:0][1:0] lc;
  bpan_status_t     st;
  logic             sp, gp, tp, mp;
  int               error_cnt = 0, checks_done = 0, n_sp = 0, n_gp = 0, n_tp = 0, n_mp = 0;
  always #2 clk = ~clk;
  bpan_core #(.P_HOLD_CYCLES(4), .P_LINK_WAIT_CYCLES(16)) dut (.i_clock(clk), .i_rst(rst), .i_clk_en(1'b1),
    .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdat),
    .i_rx_word(rxw), .i_rx_word_valid(rxv), .o_tx_word(txw), .i_pcs_rx_link_up(lup), .i_scan_link_up(scan),
    .o_link_ctl(lc), .o_status(st), .o_negotiation_start_pulse(sp), .o_good_check_entry_pulse(gp),
    .o_training_start_pulse(tp), .o_mission_start_pulse(mp));
  bpan_partner lp (.i_clock(clk), .i_send(send), .i_page(page), .o_word(rxw), .o_valid(rxv));
  always @(posedge clk) if (!rst) begin
    n_sp += sp;
    n_gp += gp;
    n_tp += tp;
    n_mp += mp;
  end
  // ----
  // Helpers
  // ----
  task automatic chk(input string what, input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask : rd_reg
  task automatic wait_st(input logic [5:0] s);
    logic [31:0] d;
    for (int i = 0; i < 60; i++) begin
      rd_reg(`BPAN_OFF_STATUS, d);
      if (d[13:8] === s) break;
    end
    chk("state", d[13:8], s);
  endtask : wait_st
  function automatic logic [29:0] lcx(input logic [14:0] m, input logic [1:0] c);
    for (int i = 0; i < 15; i++) lcx[2*i +: 2] = m[i] ? c : 2'h0;
  endfunction : lcx
  // ----
  // Scenarios
  // ----
  task automatic t_word();
    logic [31:0] d;
    chk("reset status", st, 6'h0);
    rd_reg(8'h10, d);
    chk("unmapped", d, 32'h0);
    for (int i = 0; i < 15; i++) begin
      wr_reg(`BPAN_OFF_ABIL, 32'h1 << i);
      @(posedge clk);
      #1;
      chk("tx abil", txw[35:21], 15'h1 << i);
    end
    wr_reg(`BPAN_OFF_CTRL, 32'hd0);
    wr_reg(`BPAN_OFF_ABIL, 32'h0);
    @(posedge clk);
    #1;
    chk("tx none", txw[35:21], 15'h0);
    chk("tx rs req", txw[42], 1'b1);
    chk("tx rs abil", txw[43], 1'b1);
    chk("tx pause", txw[10], 1'b1);
  endtask : t_word
  task automatic t_neg(input logic [14:0] ab, input logic [9:0] ctl, input int t, input logic [47:0] pg,
                       input logic [5:0] ex);
    int s0, g0, x0;
    wr_reg(`BPAN_OFF_CTRL, 32'h0);
    lup <= 1'b0;
    s0 = n_sp;
    g0 = n_gp;
    x0 = ctl[3] ? n_tp : n_mp;
    wr_reg(`BPAN_OFF_ABIL, ab);
    wr_reg(`BPAN_OFF_CTRL, ctl);
    wait_st(6'h04);
    chk("start pulses", n_sp - s0, 1);
    chk("scan ctl", lc, lcx(ab, 2'h1));
    @(posedge clk);
    page <= pg;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    wait_st(6'h10);
    chk("done early", st.negotiation_done, 1'b0);
    chk("on ctl", lc, lcx(15'h1 << t, 2'h3));
    @(posedge clk);
    lup <= 1'b1;
    wait_st(6'h20);
    chk("status", st, ex);
    chk("good pulses", n_gp - g0, 1);
    chk("phase pulse", (ctl[3] ? n_tp : n_mp) - x0, 1);
  endtask : t_neg
  task automatic t_restart();
    int s0;
    s0 = n_sp;
    wr_reg(`BPAN_OFF_CTRL, 32'hdd);
    repeat (3) @(posedge clk);
    chk("restart pulse", n_sp - s0, 1);
    chk("done cleared", st.negotiation_done, 1'b0);
  endtask : t_restart
  task automatic t_fault_bypass();
    int s0;
    wr_reg(`BPAN_OFF_CTRL, 32'h0);
    wr_reg(`BPAN_OFF_ABIL, 32'h5);
    scan <= 15'h5;
    wr_reg(`BPAN_OFF_CTRL, 32'h1);
    repeat (20) @(posedge clk);
    chk("pd fault", st.parallel_detect_error, 1'b1);
    scan <= 15'h0;
    // Stop the fault loop first so its last start pulse is not counted
    wr_reg(`BPAN_OFF_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    s0 = n_sp;
    wr_reg(`BPAN_OFF_ABIL, 32'h2004);
    wr_reg(`BPAN_OFF_CTRL, 32'h3);
    wait_st(6'h01);
    @(posedge clk);
    #1;
    chk("bypass ctl", lc, lcx(15'h2000, 2'h3));
    chk("bypass pulses", n_sp - s0, 0);
  endtask : t_fault_bypass
  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  initial begin
    #40000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_word();
    t_neg(15'h2004, 10'h0d9, 13, 48'h0c04_0080_0400, 6'h39);
    t_restart();
    t_neg(15'h0005, 10'h321, 2, 48'h4004_0080_0c00, 6'h15);
    t_fault_bypass();
    close_out();
  end
endmodule : backplane_autoneg_ability_resolution_bench
